// [common/cz_pkg.sv]
// constants, field layouts and types shared by the conveyor zone logic.
// assumes a 250 MHz module clock and a 32-bit plain register port.
package cz_pkg;
	// ************************************************************
	// geometry and bus
	// ************************************************************
	localparam int ZONES       = 2;        // zone 0 upstream, zone 1 downstream
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;
	localparam int OFF_W       = 5;        // offset bits inside one zone window
	localparam int TIME_W      = 16;
	localparam int CNT_W       = 16;
	localparam int RETRY_W     = 2;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [4:0] OFF_CFG   = 5'h00;
	localparam logic [4:0] OFF_GAP   = 5'h04;
	localparam logic [4:0] OFF_ACC   = 5'h08;
	localparam logic [4:0] OFF_HOFF  = 5'h0C;
	localparam logic [4:0] OFF_REC   = 5'h10;
	localparam logic [4:0] OFF_HOLD  = 5'h14;
	localparam logic [4:0] OFF_CMD   = 5'h18;
	localparam logic [4:0] OFF_STAT  = 5'h1C;
	localparam logic [7:0] ADDR_LOCATE = 8'h40;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CFG_MODE_LSB   = 0;     // two bits
	localparam int CFG_SKIP_REC_H = 2;
	localparam int CFG_SKIP_REC_S = 3;
	localparam int CFG_NO_RETRY   = 4;
	localparam int CFG_SKIP_HOFF  = 5;
	localparam int CFG_ACCEPTOR   = 6;
	localparam int CFG_W          = 7;
	localparam int CMD_CLEAR      = 0;
	localparam int HOLD_BIT       = 0;
	localparam int LOCATE_BIT     = 0;
	localparam int STAT_FAULT     = 0;
	localparam int STAT_KIND_H    = 1;
	localparam int STAT_KIND_S    = 2;
	localparam int STAT_MOTOR     = 3;
	localparam int STAT_CNT_LSB   = 16;

	typedef logic [1:0] cz_mode_t;
	localparam cz_mode_t MODE_SINGLE = 2'h0;
	localparam cz_mode_t MODE_BATCH  = 2'h1;
	localparam cz_mode_t MODE_GAP    = 2'h2;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS   = 4;
	localparam int TICK_US         = 1000;
	localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int TICKS_PER_S     = 1000000 / TICK_US;
	localparam int HOFF_WAIT_S     = 5;
	localparam int RECOVER_S       = 5;
	localparam int BLINK_HALF_MS   = 250;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [CFG_W-1:0]   CFG_RST   = 7'h00;
	localparam logic [TIME_W-1:0]  GAP_RST   = 16'h0000;
	localparam logic [TIME_W-1:0]  ACC_RST   = 16'h0000;
	localparam logic [TIME_W-1:0]  HOFF_RST  = TIME_W'(HOFF_WAIT_S * TICKS_PER_S);
	localparam logic [TIME_W-1:0]  REC_RST   = TIME_W'(RECOVER_S * TICKS_PER_S);
	localparam logic [TIME_W-1:0]  BLINK_TK  = TIME_W'(BLINK_HALF_MS * 1000 / TICK_US);
	localparam logic [RETRY_W-1:0] RETRY_MAX = 2'h3;
	localparam logic [ZONES-1:0]   HOLD_RST  = 2'h0;

	typedef enum logic [6:0] {
		ST_EMPTY  = 7'h01,
		ST_ACCEPT = 7'h02,
		ST_ARRIVE = 7'h04,
		ST_HELD   = 7'h08,
		ST_GAP    = 7'h10,
		ST_DISCH  = 7'h20,
		ST_FAULT  = 7'h40
	} cz_state_e;
endpackage : cz_pkg

// [rtl/cz_sync.sv]
// two flip-flop synchroniser for a bundle of independent levels.
// assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/10ps
module cz_sync #(
	parameter int W = 1
) (
	input  wire logic         clock_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= '0;
			sync_o  <= '0;
		end else begin
			meta_ff <= async_i;
			sync_o  <= meta_ff;
		end
	end
endmodule : cz_sync

// [rtl/cz_tick.sv]
// divider giving the common one-cycle time base enable for all zone delays.
// assumes CYCLES is the tick period in module clock cycles.
`timescale 1ns/10ps
module cz_tick #(
	parameter int CYCLES = 250000
) (
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	output logic      tick_o
);
	localparam int CW = $clog2(CYCLES);
	logic [CW-1:0] cnt_ff;

	if (CYCLES < 2) begin : g_bad
		$error("cz_tick: CYCLES must be at least 2");
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= '0;
			tick_o <= 1'b0;
		end else if (cnt_ff == CW'(CYCLES - 1)) begin
			cnt_ff <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule : cz_tick

// [rtl/cz_zone_ctrl.sv]
// two-zone conveyor release controller with register port and neighbour handshakes.
// assumes neighbour and sensor pins are asynchronous levels; nv_hold_i is the stored
// hold image presented by non-volatile storage from power-up onward.
//
// What this block does
// - locate-flash blinks every LED; a second locate command stops it.
// - locate-flash holds both motors stopped.
// - each zone has its own settings; writing one never touches the other.
// - release mode resets to one-by-one and a write takes effect at once.
// - release mode is chosen per zone, zones may differ.
// - batch mode releases together with the downstream accumulated carton.
// - staggered mode releases after downstream release plus own gap delay.
// - gap delay only for accumulated cartons, never for pass-through.
// - consecutive staggered zones each wait their own gap in turn.
// - accepting zone waits accept delay from sensor leading edge before motor.
// - accept delay applies only to a zone configured as accepting.
// - per-zone flag set while handoff-timeout or blocked-sensor fault is active.
// - per-zone count of all faults, cleared only by power cycle.
// - host clear command attempts to clear a blocked-sensor fault.
// - with hold set, next arriving carton stops until hold removed.
// - host-written hold goes to non-volatile storage and returns at power-up.
// - skip-recovery option per fault type clears without recovery delay.
// - three automatic clearing attempts for a blocked-sensor fault by default.
// - no-retries option makes no attempts; fault stays until sensor cleared.
// - discharging zone waits handoff limit for arrival; accepting zone signals arrival.
// - skip-handoff never raises a handoff-timeout fault; frees zone once carton has left.
// - handoff wait limit and recovery delay reset to 5 seconds.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
module cz_zone_ctrl #(
	parameter int TICK_CYCLES = cz_pkg::TICK_CYCLES_DEF
) (
	input  wire logic                      clock_i,
	input  wire logic                      rst_b_i,
	input  wire logic [cz_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [cz_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	output logic      [cz_pkg::DATA_W-1:0] reg_rdata_o,
	input  wire logic [cz_pkg::ZONES-1:0]  sensor_i,
	input  wire logic                      up_send_i,
	input  wire logic                      dn_ready_i,
	input  wire logic                      dn_arrived_i,
	input  wire logic                      dn_release_i,
	input  wire logic [cz_pkg::ZONES-1:0]  nv_hold_i,
	output logic      [cz_pkg::ZONES-1:0]  motor_o,
	output logic      [cz_pkg::ZONES:0]    led_o,
	output logic                           up_ready_o,
	output logic                           up_arrived_o,
	output logic                           up_release_o,
	output logic                           dn_send_o,
	output logic                           nv_wr_o,
	output logic      [cz_pkg::ZONES-1:0]  nv_hold_o
);
	import cz_pkg::*;

	if (TICK_CYCLES < 2) begin : g_bad
		$error("cz_zone_ctrl: TICK_CYCLES must be at least 2");
	end

	// ************************************************************
	// pin synchronisation and time base
	// ************************************************************
	localparam int SW = 2 * ZONES + 4;
	logic [SW-1:0]    pins_s;
	logic [ZONES-1:0] sens_s;
	logic [ZONES-1:0] nvh_s;
	logic             up_send_s;
	logic             dn_ready_s;
	logic             dn_arr_s;
	logic             dn_rel_s;
	logic             tick;

	cz_sync #(.W(SW)) u_sync (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.async_i ({nv_hold_i, dn_release_i, dn_arrived_i, dn_ready_i, up_send_i, sensor_i}),
		.sync_o  (pins_s)
	);
	assign {nvh_s, dn_rel_s, dn_arr_s, dn_ready_s, up_send_s, sens_s} = pins_s;

	// one shared tick so every delay has the same resolution
	cz_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.tick_o  (tick)
	);

	// ************************************************************
	// register decode
	// ************************************************************
	logic [OFF_W-1:0] off;
	logic             zone_hit;
	logic             loc_wr;
	assign off      = reg_addr_i[OFF_W-1:0];
	assign zone_hit = (reg_addr_i[ADDR_W-1:OFF_W+1] == '0);
	assign loc_wr   = reg_wr_i && (reg_addr_i == ADDR_LOCATE);

	logic [CFG_W-1:0]  cfg_ff  [ZONES];
	logic [TIME_W-1:0] gap_ff  [ZONES];
	logic [TIME_W-1:0] acc_ff  [ZONES];
	logic [TIME_W-1:0] hoff_ff [ZONES];
	logic [TIME_W-1:0] rec_ff  [ZONES];
	logic [CNT_W-1:0]  cnt_ff  [ZONES];
	logic [1:0]        kind_ff [ZONES];
	logic [ZONES-1:0]  hold_ff;
	logic [ZONES-1:0]  flag_w;
	logic [ZONES-1:0]  ready_w;
	logic [ZONES-1:0]  send_w;
	logic [ZONES-1:0]  arr_ff;
	logic [ZONES-1:0]  rel_ff;
	logic [ZONES-1:0]  motor_ff;
	logic [ZONES-1:0]  ready_in;
	logic [ZONES-1:0]  arr_in;
	logic [ZONES-1:0]  drel_in;
	logic [ZONES-1:0]  send_in;
	logic              flash_ff;

	// ************************************************************
	// neighbour wiring: zone 0 feeds zone 1, zone 1 feeds the next module
	// ************************************************************
	assign send_in  = {send_w[0], up_send_s};
	assign ready_in = {dn_ready_s, ready_w[1]};
	assign arr_in   = {dn_arr_s, arr_ff[1]};
	assign drel_in  = {dn_rel_s, rel_ff[1]};

	// ************************************************************
	// locate flash and blink
	// ************************************************************
	logic [TIME_W-1:0] blink_cnt_ff;
	logic              blink_ff;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flash_ff <= 1'b0;
		end else if (loc_wr && reg_wdata_i[LOCATE_BIT]) begin
			flash_ff <= !flash_ff;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			blink_cnt_ff <= '0;
			blink_ff     <= 1'b0;
		end else if (!flash_ff) begin
			blink_cnt_ff <= '0;
			blink_ff     <= 1'b0;
		end else if (tick) begin
			if (blink_cnt_ff >= BLINK_TK - 1'b1) begin
				blink_cnt_ff <= '0;
				blink_ff     <= !blink_ff;
			end else begin
				blink_cnt_ff <= blink_cnt_ff + 1'b1;
			end
		end
	end

	// ************************************************************
	// accumulate hold with non-volatile image
	// ************************************************************
	// wait for the synchroniser to fill before taking the stored image
	logic [1:0] load_cnt_ff;
	logic       hold_wr;
	assign hold_wr = reg_wr_i && zone_hit && (off == OFF_HOLD);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			load_cnt_ff <= 2'h0;
			hold_ff     <= HOLD_RST;
			nv_wr_o     <= 1'b0;
		end else begin
			nv_wr_o <= 1'b0;
			if (load_cnt_ff != 2'h3) begin
				load_cnt_ff <= load_cnt_ff + 2'h1;
				if (load_cnt_ff == 2'h2) begin
					hold_ff <= nvh_s;
				end
			end else if (hold_wr) begin
				hold_ff[reg_addr_i[OFF_W]] <= reg_wdata_i[HOLD_BIT];
				nv_wr_o                    <= 1'b1;
			end
		end
	end
	assign nv_hold_o = hold_ff;

	// ************************************************************
	// per-zone settings and release machine
	// ************************************************************
	for (genvar z = 0; z < ZONES; z++) begin : g_zone
		logic              wr_z;
		logic              clr_ff;
		logic              sens_d_ff;
		logic [TIME_W-1:0] tmr_ff;
		logic [RETRY_W-1:0] retry_ff;
		cz_state_e         state_ff;
		cz_state_e         nxt_state;
		cz_mode_t          mode;
		logic              rel_req;
		logic              rec_done;
		logic              fault_h;
		logic              fault_s;

		assign wr_z = reg_wr_i && zone_hit && (reg_addr_i[OFF_W] == 1'(z));
		assign mode = cfg_ff[z][CFG_MODE_LSB +: 2];

		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				cfg_ff[z]  <= CFG_RST;
				gap_ff[z]  <= GAP_RST;
				acc_ff[z]  <= ACC_RST;
				hoff_ff[z] <= HOFF_RST;
				rec_ff[z]  <= REC_RST;
			end else if (wr_z) begin
				case (off)
					OFF_CFG:  cfg_ff[z]  <= reg_wdata_i[CFG_W-1:0];
					OFF_GAP:  gap_ff[z]  <= reg_wdata_i[TIME_W-1:0];
					OFF_ACC:  acc_ff[z]  <= reg_wdata_i[TIME_W-1:0];
					OFF_HOFF: hoff_ff[z] <= reg_wdata_i[TIME_W-1:0];
					OFF_REC:  rec_ff[z]  <= reg_wdata_i[TIME_W-1:0];
					default: ;
				endcase
			end
		end

		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				clr_ff <= 1'b0;
			end else begin
				clr_ff <= wr_z && (off == OFF_CMD) && reg_wdata_i[CMD_CLEAR];
			end
		end

		// batch follows the downstream release edge or an empty downstream zone
		always_comb begin
			case (mode)
				MODE_BATCH: rel_req = ready_in[z] || drel_in[z];
				MODE_GAP:   rel_req = ready_in[z] || drel_in[z];
				default:    rel_req = ready_in[z];
			endcase
		end

		assign rec_done = kind_ff[z][1] ? (cfg_ff[z][CFG_SKIP_REC_S] || tmr_ff >= rec_ff[z])
		                                : (cfg_ff[z][CFG_SKIP_REC_H] || tmr_ff >= rec_ff[z]);

		always_comb begin
			nxt_state = state_ff;
			fault_h   = 1'b0;
			fault_s   = 1'b0;
			case (state_ff)
				ST_EMPTY: begin
					if (sens_s[z] && !sens_d_ff) begin
						nxt_state = cfg_ff[z][CFG_ACCEPTOR] ? ST_ACCEPT : ST_ARRIVE;
					end
				end
				ST_ACCEPT: begin
					if (tmr_ff >= acc_ff[z]) begin
						nxt_state = ST_ARRIVE;
					end
				end
				ST_ARRIVE: begin
					// a passing carton goes straight on, no gap applied
					if (hold_ff[z] || !ready_in[z]) begin
						nxt_state = ST_HELD;
					end else begin
						nxt_state = ST_DISCH;
					end
				end
				ST_HELD: begin
					if (!hold_ff[z] && rel_req) begin
						nxt_state = (mode == MODE_GAP) ? ST_GAP : ST_DISCH;
					end
				end
				ST_GAP: begin
					if (tmr_ff >= gap_ff[z]) begin
						nxt_state = ST_DISCH;
					end
				end
				ST_DISCH: begin
					if (arr_in[z]) begin
						nxt_state = ST_EMPTY;
					end else if (cfg_ff[z][CFG_SKIP_HOFF] && !sens_s[z]) begin
						nxt_state = ST_EMPTY;
					end else if (tmr_ff >= hoff_ff[z]) begin
						if (sens_s[z]) begin
							nxt_state = ST_FAULT;
							fault_s   = 1'b1;
						end else if (!cfg_ff[z][CFG_SKIP_HOFF]) begin
							nxt_state = ST_FAULT;
							fault_h   = 1'b1;
						end
					end
				end
				ST_FAULT: begin
					if (kind_ff[z][1]) begin
						if (!sens_s[z]) begin
							nxt_state = ST_EMPTY;
						end else if (clr_ff) begin
							nxt_state = ST_DISCH;
						end else if (rec_done && !cfg_ff[z][CFG_NO_RETRY] && retry_ff != '0) begin
							nxt_state = ST_DISCH;
						end
					end else if (rec_done) begin
						nxt_state = sens_s[z] ? ST_HELD : ST_EMPTY;
					end
				end
				default: nxt_state = ST_EMPTY;
			endcase
		end

		// the whole zone freezes while locating so no delay expires unseen
		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				state_ff  <= ST_EMPTY;
				sens_d_ff <= 1'b0;
				tmr_ff    <= '0;
			end else if (!flash_ff) begin
				state_ff  <= nxt_state;
				sens_d_ff <= sens_s[z];
				if (nxt_state != state_ff) begin
					tmr_ff <= '0;
				end else if (tick && tmr_ff != '1) begin
					tmr_ff <= tmr_ff + 1'b1;
				end
			end
		end

		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				retry_ff <= RETRY_MAX;
			end else if (!flash_ff) begin
				if (state_ff == ST_EMPTY) begin
					retry_ff <= RETRY_MAX;
				end else if (state_ff == ST_FAULT && nxt_state == ST_DISCH && !clr_ff) begin
					retry_ff <= retry_ff - 1'b1;
				end
			end
		end

		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				kind_ff[z] <= 2'h0;
				cnt_ff[z]  <= '0;
			end else if (!flash_ff) begin
				if (fault_h || fault_s) begin
					kind_ff[z] <= {fault_s, fault_h};
					if (cnt_ff[z] != '1) begin
						cnt_ff[z] <= cnt_ff[z] + 1'b1;
					end
				end else if (nxt_state != ST_FAULT) begin
					kind_ff[z] <= 2'h0;
				end
			end
		end

		assign flag_w[z]  = (state_ff == ST_FAULT);
		assign ready_w[z] = (state_ff == ST_EMPTY) && !flash_ff;
		assign send_w[z]  = (state_ff == ST_DISCH) && !flash_ff;

		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				motor_ff[z] <= 1'b0;
				arr_ff[z]   <= 1'b0;
				rel_ff[z]   <= 1'b0;
			end else begin
				motor_ff[z] <= !flash_ff && ((state_ff == ST_DISCH) ||
					(state_ff == ST_EMPTY && send_in[z] && !cfg_ff[z][CFG_ACCEPTOR]));
				arr_ff[z]   <= !flash_ff && state_ff == ST_EMPTY && sens_s[z] && !sens_d_ff;
				rel_ff[z]   <= !flash_ff && (state_ff == ST_HELD || state_ff == ST_GAP) &&
				               nxt_state == ST_DISCH;
			end
		end
	end

	// ************************************************************
	// outputs and read port
	// ************************************************************
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			led_o      <= '0;
			up_ready_o <= 1'b0;
			dn_send_o  <= 1'b0;
		end else begin
			led_o      <= flash_ff ? {(ZONES+1){blink_ff}} : {flag_w, 1'b1};
			up_ready_o <= ready_w[0];
			dn_send_o  <= send_w[1];
		end
	end
	assign motor_o      = motor_ff;
	assign up_arrived_o = arr_ff[0];
	assign up_release_o = rel_ff[0];

	logic [DATA_W-1:0] rd_val;
	logic              zs;
	assign zs = reg_addr_i[OFF_W];

	always_comb begin
		rd_val = '0;
		if (reg_addr_i == ADDR_LOCATE) begin
			rd_val[LOCATE_BIT] = flash_ff;
		end else if (zone_hit) begin
			case (off)
				OFF_CFG:  rd_val[CFG_W-1:0]  = cfg_ff[zs];
				OFF_GAP:  rd_val[TIME_W-1:0] = gap_ff[zs];
				OFF_ACC:  rd_val[TIME_W-1:0] = acc_ff[zs];
				OFF_HOFF: rd_val[TIME_W-1:0] = hoff_ff[zs];
				OFF_REC:  rd_val[TIME_W-1:0] = rec_ff[zs];
				OFF_HOLD: rd_val[HOLD_BIT]   = hold_ff[zs];
				OFF_STAT: begin
					rd_val[STAT_FAULT]                = flag_w[zs];
					rd_val[STAT_KIND_H]               = kind_ff[zs][0];
					rd_val[STAT_KIND_S]               = kind_ff[zs][1];
					rd_val[STAT_MOTOR]                = motor_ff[zs];
					rd_val[STAT_CNT_LSB +: CNT_W]     = cnt_ff[zs];
				end
				default: rd_val = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_val : '0;
		end
	end
endmodule : cz_zone_ctrl

// [testbench/cz_zone_ctrl_asserts.sv]
// port-level checker for the two-zone release controller.
// assumes it is bound to cz_zone_ctrl and sees nothing but its ports.
`timescale 1ns/10ps
module cz_zone_ctrl_asserts (
	input  wire logic                      clock_i,
	input  wire logic                      rst_b_i,
	input  wire logic [cz_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [cz_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	input  wire logic [cz_pkg::DATA_W-1:0] reg_rdata_o,
	input  wire logic [cz_pkg::ZONES-1:0]  motor_o,
	input  wire logic                      up_arrived_o,
	input  wire logic                      up_release_o,
	input  wire logic                      nv_wr_o,
	input  wire logic [cz_pkg::ZONES-1:0]  nv_hold_o
);
	import cz_pkg::*;
	// ********************
	// locate shadow
	// ********************
	logic loc_ff;
	logic hold_wr;
	assign hold_wr = reg_wr_i && reg_addr_i == {3'h0, OFF_HOLD};
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			loc_ff <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == ADDR_LOCATE && reg_wdata_i[LOCATE_BIT]) begin
			loc_ff <= !loc_ff;
		end
	end
	// ********************
	// properties
	// ********************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
		else $error("read data not idle");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i[7] |=> reg_rdata_o == '0)
		else $error("unmapped read not zero");
	a_cmd_reads_zero: assert property (reg_rd_i && reg_addr_i == {3'h0, OFF_CMD}
		|=> reg_rdata_o == '0) else $error("command register read not zero");
	a_locate_stop: assert property (loc_ff && $past(loc_ff) && $past(loc_ff, 2)
		|-> motor_o == '0) else $error("motor runs during locate");
	a_hold_store: assert property (hold_wr |-> ##[1:2] nv_wr_o)
		else $error("hold write not stored");
	a_hold_image: assert property (hold_wr |=> ##1 nv_hold_o[0] == $past(reg_wdata_i[0], 2))
		else $error("stored hold image wrong");
	a_arrive_pulse: assert property (up_arrived_o |=> !up_arrived_o)
		else $error("arrival pulse too long");
	a_release_pulse: assert property (up_release_o |=> !up_release_o)
		else $error("release pulse too long");
	c_locate: cover property (loc_ff ##1 !loc_ff);
	c_hold: cover property (nv_wr_o);
	c_arrive: cover property (up_arrived_o);
endmodule : cz_zone_ctrl_asserts

bind cz_zone_ctrl cz_zone_ctrl_asserts u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .motor_o(motor_o), .up_arrived_o(up_arrived_o),
	.up_release_o(up_release_o), .nv_wr_o(nv_wr_o), .nv_hold_o(nv_hold_o));

// [testbench/cz_nbr_model.sv]
// downstream neighbour: takes our discharge and reports arrival.
// assumes one module clock; stall and mute are commanded by the bench.
`timescale 1ns/10ps
module cz_nbr_model (
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	input  wire logic send_i,
	input  wire logic stall_i,
	input  wire logic mute_i,
	input  wire logic slow_i,
	output logic      ready_o,
	output logic      arrived_o,
	output logic      release_o
);
	// ********************
	// neighbour behaviour
	// ********************
	logic [3:0] dly_ff;
	logic       stall_ff;
	assign ready_o = !stall_i;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dly_ff    <= 4'h0;
			stall_ff  <= 1'b0;
			arrived_o <= 1'b0;
			release_o <= 1'b0;
		end else begin
			dly_ff    <= send_i ? dly_ff + ((dly_ff != 4'hF) ? 4'h1 : 4'h0) : 4'h0;
			// mute leaves the carton lost so the sender must time out
			arrived_o <= send_i && !mute_i && dly_ff >= (slow_i ? 4'hC : 4'h2);
			stall_ff  <= stall_i;
			release_o <= stall_ff && !stall_i;
		end
	end
endmodule : cz_nbr_model

// [testbench/cz_zone_ctrl_test.sv]
// self-checking bench for the two-zone release controller.
// assumes a short tick of 4 cycles; the neighbour model sits downstream.
`timescale 1ns/10ps
module cz_zone_ctrl_test;
	import cz_pkg::*;
	logic              clock_i;
	logic              rst_b_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i;
	logic              reg_wr_i;
	logic              reg_rd_i;
	logic [DATA_W-1:0] reg_rdata_o;
	logic [ZONES-1:0]  sensor_i;
	logic [ZONES-1:0]  motor_o;
	logic [ZONES:0]    led_o;
	logic [ZONES:0]    led_l;
	logic              up_ready_o, up_arrived_o, up_release_o, dn_send_o, nv_wr_o;
	logic              dn_ready_i, dn_arrived_i, dn_release_i, stall, mute, slow, zr;
	logic [ZONES-1:0]  nv_hold_o;
	logic [TIME_W-1:0] gap_sh [2];
	int                errors, cmp_count, seed, cyc, chg;
	cz_zone_ctrl #(.TICK_CYCLES(4)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sensor_i(sensor_i), .up_send_i(1'b0),
		.dn_ready_i(dn_ready_i), .dn_arrived_i(dn_arrived_i), .dn_release_i(dn_release_i),
		.nv_hold_i(2'b10), .motor_o(motor_o), .led_o(led_o), .up_ready_o(up_ready_o),
		.up_arrived_o(up_arrived_o), .up_release_o(up_release_o), .dn_send_o(dn_send_o),
		.nv_wr_o(nv_wr_o), .nv_hold_o(nv_hold_o));
	cz_nbr_model u_nbr (.clock_i(clock_i), .rst_b_i(rst_b_i), .send_i(dn_send_o),
		.stall_i(stall), .mute_i(mute), .slow_i(slow), .ready_o(dn_ready_i),
		.arrived_o(dn_arrived_i), .release_o(dn_release_i));
	// ********************
	// helpers
	// ********************
	function automatic logic [7:0] za(input logic z, input logic [4:0] o);
		return {2'b00, z, o};
	endfunction : za
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			errors++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clock_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clock_i);
		reg_rd_i   <= 1'b0;
		#1;
		chk(n, e, reg_rdata_o & m);
	endtask : rchk
	// zone 1 hands its carton on; sensor clears 3 cycles after send is seen
	task automatic pass_z1;
		for (int i = 0; i < 200 && dn_send_o !== 1'b1; i++) @(posedge clock_i);
		chk("send", 32'h1, 32'(dn_send_o));
		repeat (3) @(posedge clock_i);
		sensor_i <= 2'b00;
		for (int i = 0; i < 60 && dn_send_o !== 1'b0; i++) @(posedge clock_i);
		chk("send end", 32'h0, 32'(dn_send_o));
	endtask : pass_z1
	task automatic end_of_test;
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// ********************
	// clock, timeout, sequence
	// ********************
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		{rst_b_i, reg_wr_i, reg_rd_i, stall, mute, slow} = '0;
		{reg_addr_i, reg_wdata_i, sensor_i} = '0;
		{errors, cmp_count, cyc} = '0;
		seed = 9;
		gap_sh = '{16'h0000, 16'h0000};
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		for (int z = 0; z < 2; z++) begin
			rchk("cfg", za(z[0], OFF_CFG), 32'h7F, 32'h0);
			rchk("hoff", za(z[0], OFF_HOFF), 32'hFFFF, 32'(HOFF_WAIT_S * TICKS_PER_S));
			rchk("rec", za(z[0], OFF_REC), 32'hFFFF, 32'(RECOVER_S * TICKS_PER_S));
			rchk("hold", za(z[0], OFF_HOLD), 32'h1, 32'(z));
		end
		for (int k = 0; k < 6; k++) begin
			zr = 1'($random(seed));
			gap_sh[zr] = 16'($random(seed));
			wr(za(zr, OFF_GAP), {16'h0000, gap_sh[zr]});
			rchk("gap0", za(1'b0, OFF_GAP), 32'hFFFF, {16'h0000, gap_sh[0]});
			rchk("gap1", za(1'b1, OFF_GAP), 32'hFFFF, {16'h0000, gap_sh[1]});
		end
		for (int m = 0; m < 3; m++) begin
			wr(za(1'b0, OFF_CFG), 32'(m));
			wr(za(1'b1, OFF_CFG), 32'((m + 1) % 3));
			rchk("mode0", za(1'b0, OFF_CFG), 32'h3, 32'(m));
			rchk("mode1", za(1'b1, OFF_CFG), 32'h3, 32'((m + 1) % 3));
		end
		wr(za(1'b0, OFF_CFG), 32'h0);
		rchk("unmapped", 8'h80, 32'hFFFFFFFF, 32'h0);
		rchk("cmd", za(1'b0, OFF_CMD), 32'hFFFFFFFF, 32'h0);
		wr(za(1'b1, OFF_HOLD), 32'h0);
		wr(za(1'b0, OFF_HOLD), 32'h1);
		sensor_i <= 2'b01;
		repeat (40) @(posedge clock_i);
		chk("held", 32'h0, 32'(motor_o[0]));
		wr(za(1'b0, OFF_HOLD), 32'h0);
		for (int i = 0; i < 60 && motor_o[0] !== 1'b1; i++) @(posedge clock_i);
		chk("freed", 32'h1, 32'(motor_o[0]));
		sensor_i <= 2'b10;
		slow <= 1'b1;
		pass_z1();
		wr(ADDR_LOCATE, 32'h1);
		rchk("locate on", ADDR_LOCATE, 32'h1, 32'h1);
		sensor_i <= 2'b10;
		led_l = led_o;
		chg = 0;
		repeat (2000) begin
			@(negedge clock_i);
			chg += (led_o !== led_l);
			led_l = led_o;
		end
		chk("stopped", 32'h0, 32'(motor_o));
		chk("blink", 32'h1, 32'(chg > 0));
		wr(ADDR_LOCATE, 32'h1);
		rchk("locate off", ADDR_LOCATE, 32'h1, 32'h0);
		slow <= 1'b0;
		pass_z1();
		wr(za(1'b1, OFF_HOFF), 32'h3);
		mute <= 1'b1;
		sensor_i <= 2'b10;
		repeat (200) @(posedge clock_i);
		rchk("fault", za(1'b1, OFF_STAT), 32'hFFFF0005, 32'h00010005);
		wr(za(1'b1, OFF_CMD), 32'h1);
		repeat (40) @(posedge clock_i);
		mute <= 1'b0;
		sensor_i <= 2'b00;
		repeat (40) @(posedge clock_i);
		rchk("cleared", za(1'b1, OFF_STAT), 32'hFFFF0001, 32'h00020000);
		end_of_test();
	end
endmodule : cz_zone_ctrl_test
